/* File: rtl/lef_pkg.sv */
// Shared constants and types for the latched event flag bank.
// Assumes one 25 MHz clock and host register accesses on that clock.
`default_nettype none
package lef_pkg;

    // Clock rate, kept for reference by timing users
    localparam int LEF_CLK_HZ = 25_000_000;

    // Register map: one latched flag register per index, mask at +delta
    localparam int LEF_NREG = 11;
    localparam int LEF_AW   = 16;
    typedef logic [LEF_AW-1:0] lef_addr_t;
    typedef logic [3:0]        lef_idx_t;
    typedef logic [7:0]        lef_byte_t;

    localparam lef_addr_t LEF_FLAG_OFS [LEF_NREG] = '{
        16'h0E23, 16'h0E24, 16'h0E26, 16'h0E27, 16'h0E28, 16'h0E29,
        16'h0E2B, 16'h0E32, 16'h0E33, 16'h0E34, 16'h0E35
    };
    localparam lef_addr_t LEF_MASK_DELTA = 16'h0020;
    localparam lef_byte_t LEF_RST_VAL    = 8'h00;
    localparam lef_byte_t LEF_ALL_ONES   = 8'hFF;

    // Register indices
    localparam lef_idx_t LEF_I_SUPPLY = 4'h0;
    localparam lef_idx_t LEF_I_CONV   = 4'h1;
    localparam lef_idx_t LEF_I_GLR    = 4'h2;
    localparam lef_idx_t LEF_I_GHR    = 4'h3;
    localparam lef_idx_t LEF_I_GLF    = 4'h4;
    localparam lef_idx_t LEF_I_GHF    = 4'h5;
    localparam lef_idx_t LEF_I_USB    = 4'h6;
    localparam lef_idx_t LEF_I_TEMP   = 4'h7;
    localparam lef_idx_t LEF_I_IDR    = 4'h8;
    localparam lef_idx_t LEF_I_IDF    = 4'h9;
    localparam lef_idx_t LEF_I_OSC    = 4'hA;

    // Edge detector settles after this many cycles out of reset
    localparam logic [1:0] LEF_WARM = 2'h3;

    // Every watched source condition, as levels
    typedef struct packed {
        logic       backup_above;
        logic       main_above;
        logic       cc_cal;
        logic       cc_conv;
        logic       cc_accum;
        logic       sound;
        logic       conv_soft;
        logic       conv_pin;
        logic       acc2_first;
        logic       acc2_second;
        logic       acc1;
        logic [7:0] gpio_low;
        logic [7:0] gpio_high;
        logic [3:0] link;
        logic       phy_loss;
        logic       sense_fail;
        logic       unplug;
        logic       plug;
        logic       sink_to;
        logic       source_to;
        logic [3:0] temp_zone;
        logic [3:0] id_res;
        logic       id_line;
        logic       bad_chg;
        logic       srp;
        logic       safe_stop;
        logic       resume;
        logic       osc_fail;
        logic       cur_lim;
        logic       main_th;
        logic       usb_th;
    } lef_src_t;
    localparam int LEF_SW = $bits(lef_src_t);

    // Edge detector state
    typedef struct packed {
        lef_src_t   s1;
        lef_src_t   s2;
        lef_src_t   prev;
        logic [1:0] warm;
    } lef_edge_t;

    // Flag bank state
    typedef struct packed {
        logic [LEF_NREG-1:0][7:0] flag;
        logic [LEF_NREG-1:0][7:0] mask;
        lef_byte_t                rdata;
        logic                     rvalid;
        logic                     irq;
    } lef_bank_t;

endpackage
`default_nettype wire

/* File: rtl/lef_edge_if.sv */
// Carrier between the flag bank and its edge detector.
// Assumes both ends run on mclk.
`timescale 1ns/1ps
`default_nettype none
interface lef_edge_if;
    import lef_pkg::*;
    lef_src_t lvl;
    lef_src_t rise;
    lef_src_t fall;
    logic     clr;
    modport det (input lvl, input clr, output rise, output fall);
    modport usr (output lvl, output clr, input rise, input fall);
endinterface
`default_nettype wire

/* File: rtl/lef_edge_det.sv */
// Two-stage synchroniser and edge detector for all source conditions.
// Assumes levels arrive from outside the mclk domain; clr is synchronous.
`timescale 1ns/1ps
`default_nettype none
module lef_edge_det import lef_pkg::*; (
    // Clock
    input wire logic mclk,
    // Levels in, one-cycle edges out
    lef_edge_if.det  io
);
    lef_edge_t              st_ff;
    lef_edge_t              nxt_st;
    logic                   armed;
    logic [LEF_SW-1:0]      lvl_v;
    logic [LEF_SW-1:0]      rise_v;
    logic [LEF_SW-1:0]      fall_v;

    // Sync chain; s1 feeds only s2
    always_comb begin
        nxt_st      = st_ff;
        nxt_st.s1   = io.lvl;
        nxt_st.s2   = st_ff.s1;
        nxt_st.prev = st_ff.s2;
        if (st_ff.warm != LEF_WARM) begin
            nxt_st.warm = st_ff.warm + 2'h1;
        end
        if (io.clr) begin
            nxt_st = '0;
        end
    end

    always_ff @(posedge mclk) begin
        st_ff <= nxt_st;
    end

    // Held off until prev is valid, so a level high at reset is no edge
    assign armed   = (st_ff.warm == LEF_WARM);
    assign lvl_v   = io.lvl;
    assign rise_v  = armed ? (st_ff.s2 & ~st_ff.prev) : '0;
    assign fall_v  = armed ? (~st_ff.s2 & st_ff.prev) : '0;
    assign io.rise = lef_src_t'(rise_v);
    assign io.fall = lef_src_t'(fall_v);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (io.clr);

    sequence up_seen;
        armed ##0 $rose(lvl_v[0]);
    endsequence
    sequence down_seen;
        armed ##0 $fell(lvl_v[0]);
    endsequence

    edge_rise_lat_a: assert property (up_seen |-> ##2 rise_v[0])
        else $error("rising level not reported two cycles later");
    edge_fall_lat_a: assert property (down_seen |-> ##2 fall_v[0])
        else $error("falling level not reported two cycles later");
    edge_idle_a: assert property (!armed |-> (rise_v == '0 && fall_v == '0))
        else $error("edge reported before detector settled");
    edge_pulse_a: assert property (rise_v[0] |=> !rise_v[0])
        else $error("edge pulse longer than one cycle");
    // Warm-up must last exactly three cycles after a clear
    edge_warm_a: assert property ($fell(io.clr) |-> !armed ##1 !armed ##1 !armed ##1 armed)
        else $error("detector warm-up length wrong after clear");

endmodule // lef_edge_det
`default_nettype wire

/* File: rtl/lef_flag_bank.sv */
// Latched event flag bank: clear-on-read flags, mask registers, request.
// Assumes host read/write strobes on mclk; source levels come from pins
// or other blocks and are synchronised here.
//
// Operation
// - Reading a flag register clears its set bits; each event reports once.
// - All flags return to zero on any of the four resets.
// - Backup cell above charge setting sets bit 7, below sets bit 6.
// - Main cell above low threshold sets bit 5, below sets bit 4.
// - Counter calibration, conversion and accumulation done set bits 3, 2, 0.
// - Sound section request sets bit 1 of the supply register.
// - Converter soft done sets bit 7, pin-triggered done sets bit 0.
// - Accessory 2 threshold crossings set bits 6 to 3.
// - Accessory 1 rising sets bit 2, falling sets bit 1.
// - Rising edges on both pin groups latch into the rise registers.
// - Falling edges on both pin groups latch into the fall registers.
// - Any change of link state sets bit 7 of the attach register.
// - Transceiver reset by power loss sets bit 6.
// - Attach sense failure sets bit 4; unplug bit 3, plug bit 2.
// - Attach sink and source timeouts set bits 1 and 0.
// - Cell temperature zones hot, warm, mild, cold set bits 3 to 0.
// - Id resistance rising past four thresholds sets bits 7 to 4.
// - Id resistance falling below four thresholds sets bits 5 to 2.
// - Id line rising edge and falling edge set their own flags.
// - Bad bus charger sets bit 1, session request sets bit 0.
// - A safety charge stop sampled high at one or more mclk edges sets bit 7.
// - Automatic charge restart after a safety stop sets bit 6.
// - A set mask bit keeps its flag off the interrupt request.
`timescale 1ns/1ps
`default_nettype none
module lef_flag_bank import lef_pkg::*; (
    // Clock and resets, all synchronous and active high
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        standard_register_reset,
    input  wire logic        digital_power_on_reset,
    input  wire logic        switch_off_reset,
    // Host register access
    input  wire logic        host_rd,
    input  wire logic        host_wr,
    input  wire lef_addr_t   host_addr,
    input  wire lef_byte_t   host_wdata,
    output var  lef_byte_t   host_rdata,
    output var  logic        host_rvalid,
    output var  logic        irq_req,
    // Supply, counter and sound sources
    input  wire logic        backup_cell_above,
    input  wire logic        main_cell_above,
    input  wire logic        charge_counter_cal_done,
    input  wire logic        charge_counter_conv_done,
    input  wire logic        charge_counter_accum_done,
    input  wire logic        sound_section_event,
    // Converter and accessory sources
    input  wire logic        converter_soft_done,
    input  wire logic        converter_pin_done,
    input  wire logic        acc2_above_first,
    input  wire logic        acc2_above_second,
    input  wire logic        acc1_above,
    // General purpose pins
    input  wire logic [7:0]  gpio_low_pins,
    input  wire logic [7:0]  gpio_high_pins,
    // Bus attach sources
    input  wire logic [3:0]  usb_link_state,
    input  wire logic        transceiver_power_loss,
    input  wire logic        attach_sense_fail,
    input  wire logic        attach_unplug,
    input  wire logic        attach_plug,
    input  wire logic        attach_sink_timeout,
    input  wire logic        attach_source_timeout,
    // Temperature, id line and charger sources
    input  wire logic [3:0]  cell_temp_zone,
    input  wire logic [3:0]  idline_res_above,
    input  wire logic        idline_level,
    input  wire logic        bad_bus_charger,
    input  wire logic        session_request,
    input  wire logic        charge_safety_stop,
    input  wire logic        charge_resume,
    // Oscillator and thermal sources
    input  wire logic        osc_start_fail,
    input  wire logic        charge_cur_limited,
    input  wire logic        main_thermal_prot,
    input  wire logic        usb_thermal_prot
);
    lef_bank_t                st_ff;
    lef_bank_t                nxt_st;
    logic [LEF_NREG-1:0][7:0] set;
    logic                     clr_all;
    logic                     link_chg;
    lef_src_t                 r;
    lef_src_t                 f;
    lef_edge_if               eif ();

    // Any of the four resets empties the bank
    assign clr_all = reset | standard_register_reset
                   | digital_power_on_reset | switch_off_reset;

    // Gather every source level into one bundle
    assign eif.clr = clr_all;
    assign eif.lvl = '{
        backup_above: backup_cell_above,
        main_above:   main_cell_above,
        cc_cal:       charge_counter_cal_done,
        cc_conv:      charge_counter_conv_done,
        cc_accum:     charge_counter_accum_done,
        sound:        sound_section_event,
        conv_soft:    converter_soft_done,
        conv_pin:     converter_pin_done,
        acc2_first:   acc2_above_first,
        acc2_second:  acc2_above_second,
        acc1:         acc1_above,
        gpio_low:     gpio_low_pins,
        gpio_high:    gpio_high_pins,
        link:         usb_link_state,
        phy_loss:     transceiver_power_loss,
        sense_fail:   attach_sense_fail,
        unplug:       attach_unplug,
        plug:         attach_plug,
        sink_to:      attach_sink_timeout,
        source_to:    attach_source_timeout,
        temp_zone:    cell_temp_zone,
        id_res:       idline_res_above,
        id_line:      idline_level,
        bad_chg:      bad_bus_charger,
        srp:          session_request,
        safe_stop:    charge_safety_stop,
        resume:       charge_resume,
        osc_fail:     osc_start_fail,
        cur_lim:      charge_cur_limited,
        main_th:      main_thermal_prot,
        usb_th:       usb_thermal_prot
    };

    lef_edge_det lef_edge_det_inst (
        .mclk (mclk),
        .io   (eif.det)
    );

    assign r = eif.rise;
    assign f = eif.fall;

    // Link state is a word; any bit moving counts as a change
    assign link_chg = |(r.link | f.link);

    // Event pulses per register, bit 7 first, reserved bits never set
    assign set[LEF_I_SUPPLY] = {r.backup_above, f.backup_above,
                                r.main_above, f.main_above,
                                r.cc_cal, r.cc_conv,
                                r.sound,
                                r.cc_accum};
    assign set[LEF_I_CONV]   = {r.conv_soft,
                                f.acc2_first, r.acc2_first,
                                f.acc2_second, r.acc2_second,
                                r.acc1, f.acc1,
                                r.conv_pin};
    assign set[LEF_I_GLR]    = r.gpio_low;
    assign set[LEF_I_GHR]    = r.gpio_high;
    assign set[LEF_I_GLF]    = f.gpio_low;
    assign set[LEF_I_GHF]    = f.gpio_high;
    assign set[LEF_I_USB]    = {link_chg,
                                r.phy_loss, 1'b0,
                                r.sense_fail, r.unplug, r.plug,
                                r.sink_to, r.source_to};
    assign set[LEF_I_TEMP]   = {4'h0, r.temp_zone};
    assign set[LEF_I_IDR]    = {r.id_res, 1'b0,
                                r.id_line,
                                r.bad_chg, r.srp};
    // Edge catch means even a brief safety stop is recorded
    assign set[LEF_I_IDF]    = {r.safe_stop,
                                r.resume,
                                f.id_res, 1'b0,
                                f.id_line};
    assign set[LEF_I_OSC]    = {r.osc_fail, r.cur_lim, f.cur_lim, 1'b0,
                                r.main_th, f.main_th, r.usb_th, f.usb_th};

    // Flag update, mask writes and read data
    always_comb begin
        nxt_st        = st_ff;
        nxt_st.rvalid = host_rd;
        nxt_st.rdata  = host_rd ? LEF_RST_VAL : st_ff.rdata;
        // Request built from registered state so it is glitch free
        nxt_st.irq    = |(st_ff.flag & ~st_ff.mask);
        for (int i = 0; i < LEF_NREG; i++) begin
            if (host_rd && host_addr == LEF_FLAG_OFS[i]) begin
                nxt_st.rdata = st_ff.flag[i];
            end
            if (host_rd && host_addr == LEF_FLAG_OFS[i] + LEF_MASK_DELTA) begin
                nxt_st.rdata = st_ff.mask[i];
            end
            // Set wins over the read clear so no event is lost
            nxt_st.flag[i] = (host_rd && host_addr == LEF_FLAG_OFS[i])
                           ? set[i]
                           : (st_ff.flag[i] | set[i]);
            if (host_wr && host_addr == LEF_FLAG_OFS[i] + LEF_MASK_DELTA) begin
                nxt_st.mask[i] = host_wdata;
            end
        end
        if (clr_all) begin
            nxt_st = '0;
        end
    end

    always_ff @(posedge mclk) begin
        st_ff <= nxt_st;
    end

    // Outputs straight from the state flops
    assign host_rdata  = st_ff.rdata;
    assign host_rvalid = st_ff.rvalid;
    assign irq_req     = st_ff.irq;

    // Checks
    logic      rd_glr;
    lef_byte_t glr_set;
    assign rd_glr  = host_rd && host_addr == LEF_FLAG_OFS[LEF_I_GLR];
    assign glr_set = set[LEF_I_GLR];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (clr_all);

    sequence glr_read_quiet;
        rd_glr ##0 (glr_set == LEF_RST_VAL);
    endsequence

    rd_clears_a: assert property (
        glr_read_quiet |=> st_ff.flag[LEF_I_GLR] == LEF_RST_VAL)
        else $error("flag register not cleared by read");
    rd_returns_a: assert property (
        rd_glr |=> host_rvalid && host_rdata == $past(st_ff.flag[LEF_I_GLR]))
        else $error("read data does not match flags");
    set_wins_a: assert property (
        rd_glr && glr_set != LEF_RST_VAL
        |=> (st_ff.flag[LEF_I_GLR] & $past(glr_set)) == $past(glr_set))
        else $error("event lost during clearing read");
    reset_zero_a: assert property (disable iff (1'b0)
        clr_all |=> st_ff.flag == '0 && !irq_req)
        else $error("flags not zero after reset");
    mask_block_a: assert property (
        (st_ff.flag & ~st_ff.mask) == '0 |=> !irq_req)
        else $error("masked flags raised the request");
    irq_raise_a: assert property (
        (st_ff.flag & ~st_ff.mask) != '0 |=> irq_req)
        else $error("unmasked flag did not raise the request");
    gpio_fall_a: assert property (
        f.gpio_high != '0 && !host_rd
        |=> (st_ff.flag[LEF_I_GHF] & $past(f.gpio_high)) == $past(f.gpio_high))
        else $error("falling pin edge not latched");
    link_chg_a: assert property (
        link_chg |=> st_ff.flag[LEF_I_USB][7])
        else $error("link state change not latched");
    flag_hold_a: assert property (
        !host_rd && st_ff.flag[LEF_I_IDF][7] |=> st_ff.flag[LEF_I_IDF][7])
        else $error("flag dropped without a read");

endmodule // lef_flag_bank
`default_nettype wire

/* File: testbench/lef_host_model.sv */
// Host model: register reads and mask writes towards the flag bank.
// Assumes the bank answers a read one edge after taking it, on mclk.
`timescale 1ns/1ps
`default_nettype none
module lef_host_model import lef_pkg::*; (
    // Clock
    input  wire logic      mclk,
    // Register access
    output logic           host_rd,
    output logic           host_wr,
    output lef_addr_t      host_addr,
    output lef_byte_t      host_wdata,
    input  wire lef_byte_t host_rdata,
    input  wire logic      host_rvalid
);
    // Idle bus at time zero
    initial begin
        host_rd    = 1'b0;
        host_wr    = 1'b0;
        host_addr  = 16'h0000;
        host_wdata = 8'h00;
    end

    // One read; answer taken at the edge after the strobe edge
    task automatic rd(input lef_addr_t a, output lef_byte_t d, output logic ok);
        @(posedge mclk);
        host_rd   <= 1'b1;
        host_addr <= a;
        @(posedge mclk);
        host_rd   <= 1'b0;
        host_addr <= ~a;  // Released address must not look valid
        @(posedge mclk);
        ok = host_rvalid;
        d  = host_rdata;
    endtask

    // One write, taken at the edge after the strobe goes up
    task automatic wr(input lef_addr_t a, input lef_byte_t d);
        @(posedge mclk);
        host_wr    <= 1'b1;
        host_addr  <= a;
        host_wdata <= d;
        @(posedge mclk);
        host_wr    <= 1'b0;
        host_addr  <= ~a;
        host_wdata <= ~d;  // Stale data changes so it is never reused
    endtask
endmodule // lef_host_model
`default_nettype wire

/* File: testbench/lef_flag_bank_bench.sv */
// Self-checking bench for the flag bank: drives sources, reads flags.
// Assumes the host model above and the four synchronous resets.
`timescale 1ns/1ps
`default_nettype none
module lef_flag_bank_bench import lef_pkg::*;;
    logic        mclk, reset, std_rst, por_rst, off_rst;
    logic        host_rd, host_wr, host_rvalid, irq_req;
    lef_addr_t   host_addr;
    lef_byte_t   host_wdata, host_rdata;
    logic [10:0] sup;
    logic [7:0]  gl, gh;
    logic [5:0]  att;
    logic [8:0]  misc;
    logic [3:0]  link, tz, idr;
    int          fails = 0;
    int          comparisons = 0;

    // Device under test with all sources driven
    lef_flag_bank lef_flag_bank_inst (.mclk(mclk), .reset(reset),
        .standard_register_reset(std_rst), .digital_power_on_reset(por_rst),
        .switch_off_reset(off_rst), .host_rd(host_rd), .host_wr(host_wr),
        .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
        .host_rvalid(host_rvalid), .irq_req(irq_req), .backup_cell_above(sup[10]),
        .main_cell_above(sup[9]), .charge_counter_cal_done(sup[8]),
        .charge_counter_conv_done(sup[7]), .charge_counter_accum_done(sup[6]),
        .sound_section_event(sup[5]), .converter_soft_done(sup[4]),
        .converter_pin_done(sup[3]), .acc2_above_first(sup[2]),
        .acc2_above_second(sup[1]), .acc1_above(sup[0]), .gpio_low_pins(gl),
        .gpio_high_pins(gh), .usb_link_state(link), .transceiver_power_loss(att[5]),
        .attach_sense_fail(att[4]), .attach_unplug(att[3]), .attach_plug(att[2]),
        .attach_sink_timeout(att[1]), .attach_source_timeout(att[0]),
        .cell_temp_zone(tz), .idline_res_above(idr), .idline_level(misc[8]),
        .bad_bus_charger(misc[7]), .session_request(misc[6]),
        .charge_safety_stop(misc[5]), .charge_resume(misc[4]),
        .osc_start_fail(misc[3]), .charge_cur_limited(misc[2]),
        .main_thermal_prot(misc[1]), .usb_thermal_prot(misc[0]));

    // Host processor on the register side
    lef_host_model lef_host_model_inst (.mclk(mclk), .host_rd(host_rd),
        .host_wr(host_wr), .host_addr(host_addr), .host_wdata(host_wdata),
        .host_rdata(host_rdata), .host_rvalid(host_rvalid));

    // 25 MHz clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic complete_run;
        if (fails == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string n, input lef_byte_t e, input lef_byte_t g);
        comparisons++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", n, e, g);
            fails++;
        end
    endtask

    // Read a register and compare, answer strobe included
    task automatic rc(input lef_addr_t a, input lef_byte_t e);
        lef_byte_t d;
        logic      ok;
        lef_host_model_inst.rd(a, d, ok);
        chk("host_rvalid", 8'h01, {7'h00, ok});
        chk($sformatf("reg %h", a), e, d);
    endtask

    // Covers the two-stage sync, the flag edge and the irq lag; the irq
    // is read at an edge, so one more edge than the irq itself needs
    task automatic settle;
        repeat (5) @(posedge mclk);
    endtask

    task automatic reset_values;
        for (int i = 0; i < LEF_NREG; i++) begin
            rc(LEF_FLAG_OFS[i], 8'h00);
            rc(LEF_FLAG_OFS[i] + LEF_MASK_DELTA, 8'h00);
        end
        rc(16'h0E25, 8'h00);
        lef_host_model_inst.wr(16'h0E26, 8'hFF);
        rc(16'h0E26, 8'h00);
    endtask

    task automatic supply_events;
        sup <= 11'h7FF;
        settle;
        rc(16'h0E23, 8'hAF);
        rc(16'h0E24, 8'hAD);
        sup <= 11'h000;
        settle;
        rc(16'h0E23, 8'h50);
        rc(16'h0E24, 8'h52);
    endtask

    task automatic gpio_events;
        gl <= 8'hA5;
        gh <= 8'h3C;
        settle;
        rc(16'h0E26, 8'hA5);
        rc(16'h0E26, 8'h00);
        rc(16'h0E27, 8'h3C);
        gl <= 8'h00;
        gh <= 8'h00;
        settle;
        rc(16'h0E28, 8'hA5);
        rc(16'h0E29, 8'h3C);
    endtask

    task automatic attach_events;
        link <= 4'h5;
        att  <= 6'h3F;
        settle;
        rc(16'h0E2B, 8'hDF);
        att <= 6'h00;
        settle;
        rc(16'h0E2B, 8'h00);
        link <= 4'h4;
        settle;
        rc(16'h0E2B, 8'h80);
    endtask

    task automatic id_charger_events;
        tz   <= 4'hF;
        idr  <= 4'hF;
        misc <= 9'h1FF;
        settle;
        rc(16'h0E32, 8'h0F);
        rc(16'h0E33, 8'hF7);
        rc(16'h0E34, 8'hC0);
        rc(16'h0E35, 8'hCA);
        tz   <= 4'h0;
        idr  <= 4'h0;
        misc <= 9'h000;
        settle;
        rc(16'h0E33, 8'h00);
        rc(16'h0E34, 8'h3D);
        rc(16'h0E35, 8'h25);
    endtask

    task automatic irq_mask;
        lef_host_model_inst.wr(16'h0E46, 8'hFF);
        rc(16'h0E46, 8'hFF);
        gl <= 8'h01;
        settle;
        chk("irq_req", 8'h00, {7'h00, irq_req});
        lef_host_model_inst.wr(16'h0E46, 8'h00);
        settle;
        chk("irq_req", 8'h01, {7'h00, irq_req});
        rc(16'h0E26, 8'h01);
        settle;
        chk("irq_req", 8'h00, {7'h00, irq_req});
        gl <= 8'h00;
        settle;
        rc(16'h0E28, 8'h01);
    endtask

    // Event lands on the very edge that takes the clearing read
    task automatic read_race;
        gh <= 8'h01;
        @(posedge mclk);
        rc(16'h0E27, 8'h00);
        rc(16'h0E27, 8'h01);
        gh <= 8'h00;
        settle;
        rc(16'h0E29, 8'h01);
    endtask

    // Each of the three other resets wipes a set flag in mid-run
    task automatic reset_each;
        for (int i = 0; i < 3; i++) begin
            gh <= 8'h80;
            settle;
            {std_rst, por_rst, off_rst} <= 3'b100 >> i;
            @(posedge mclk);
            {std_rst, por_rst, off_rst} <= 3'b000;
            settle;
            rc(16'h0E27, 8'h00);
            gh <= 8'h00;
            settle;
            rc(16'h0E29, 8'h80);
        end
    endtask

    // Main sequence
    initial begin
        {reset, std_rst, por_rst, off_rst} = 4'h8;
        {sup, gl, gh, att, misc, link, tz, idr} = '0;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        settle;  // Edges in the warm-up cycles are ignored
        reset_values;
        supply_events;
        gpio_events;
        attach_events;
        id_charger_events;
        irq_mask;
        read_race;
        reset_each;
        complete_run;
    end

    // Watchdog, far beyond the roughly 300 cycles the tests need
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        complete_run;
    end
endmodule // lef_flag_bank_bench
`default_nettype wire
